// ### sfxpc_ctrl.sv
// execute mode, escape and power-up readiness logic of a stacked serial flash
// Summary of operation
// - execute mode selected in persistent config is entered right after power-up
// - confirmation bit is io_line0 in first dummy cycle after address
// - confirmation 0 keeps execute mode, 1 returns to command operation
// - two-line execute mode ignores io_line1 in first dummy cycle
// - four-line execute mode ignores io_line3..1 in first dummy cycle
// - reset pin low pulse ends execute mode, restores persistent state
// - four-line protocol: reset pulse acts only while deselected
// - escape ends execute mode, keeps device state and running operation
// - power-on reset holds logic, no instruction answered
// - during initialisation only status and flag status reads accepted
// - after power-up: standby, write latch, busy and lock bits zero
// - flag bit 7 reads 0 while busy, 1 when done
// - readiness polling uses single line in, io_line1 out
// - once ready, protocol from persistent config applies
// - during ready wait: pause enabled, reset pin off, default drive
// - ready time stretches after interrupted subsector erase
// - in execute mode each access is address only
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sfxpc_ctrl #(
   parameter int READY_WAIT_CYCLES = sfxpc_pkg::READY_WAIT_CYC,
   parameter int REC4K_CYCLES      = sfxpc_pkg::REC4K_CYC,
   parameter int REC32K_CYCLES     = sfxpc_pkg::REC32K_CYC
) (
   // clock and reset
   input  wire logic                       clk_sys_in,
   input  wire logic                       rst_n_in,
   // power-on reset indication from the supply monitor, low while held
   input  wire logic                       por_n_in,
   // flash pins
   input  wire sfxpc_pkg::sfxpc_pins_in_t  pins_in,
   output var  sfxpc_pkg::sfxpc_pins_out_t pins_out,
   // pause pin function enable and drive strength default indication
   output logic                            pause_en_out,
   output logic                            drive_default_out,
   // apb slave
   input  wire sfxpc_pkg::sfxpc_apb_req_t  apb_in,
   output var  sfxpc_pkg::sfxpc_apb_rsp_t  apb_out
);
   // ==========================================================
   // declarations
   typedef enum logic [2:0] {SP_CMD, SP_ADDR, SP_DUMMY, SP_OUT, SP_IGNORE} sfxpc_spi_t;
   sfxpc_spi_t   spi_state;
   logic [31:0]  cfg;
   logic         op_busy;
   logic [1:0]   por_sync;
   logic [2:0]   sclk_sync;
   logic [2:0]   sel_sync;
   logic [1:0]   rpin_sync;
   logic [3:0]   io_s1;
   logic [3:0]   io_s2;
   logic         logic_rst;
   logic         sclk_rise;
   logic         sclk_fall;
   logic         sel_low;
   logic         sel_rise;
   logic [23:0]  init_cnt;
   logic         ready;
   logic         xip_active;
   logic         wel;
   logic         rst_armed;
   logic         from_cmd;
   logic [7:0]   cmd_sh;
   logic [5:0]   bit_cnt;
   logic [7:0]   out_sh;
   logic         out_bit;
   logic         xip_en;
   logic [2:0]   lanes;
   logic [5:0]   next_bit_cnt;
   logic [7:0]   next_cmd;
   logic [7:0]   status_byte;
   logic [7:0]   flag_byte;
   logic         rpin_low_q;
   logic         rpin_hit;
   logic         soft_rst;
   logic [23:0]  wait_len;
   logic         apb_hit;

   // ==========================================================
   // synchronisers for pins from outside the clock domain
   always_ff @(posedge clk_sys_in)
   begin
      por_sync  <= {por_sync[0], por_n_in};
      sclk_sync <= {sclk_sync[1:0], pins_in.sclk};
      sel_sync  <= {sel_sync[1:0], pins_in.select_n};
      rpin_sync <= {rpin_sync[0], pins_in.reset_n};
      io_s1     <= pins_in.io;
      io_s2     <= io_s1;
   end

   // edges are taken from the second and third stages only
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign sel_low   = ~sel_sync[1];
   assign sel_rise  = sel_sync[1] & ~sel_sync[2];
   // power-on reset indication holds all device logic
   assign logic_rst = ~rst_n_in | ~por_sync[1];

   // ==========================================================
   // protocol and mode decoding
   assign xip_en = cfg[sfxpc_pkg::CFG_XIP_LSB +: 3] != sfxpc_pkg::CFG_XIP_OFF;

   // single line until ready, then the configured width
   always_comb
   begin
      if (!ready)
         lanes = 3'h1;
      else if (!cfg[sfxpc_pkg::CFG_QUAD_BIT])
         lanes = 3'h4;
      else if (!cfg[sfxpc_pkg::CFG_DUAL_BIT])
         lanes = 3'h2;
      else
         lanes = 3'h1;
   end

   // shifts the sampled data lines into the command byte
   always_comb
   begin
      unique case (lanes)
         3'h4:    next_cmd = {cmd_sh[3:0], io_s2};
         3'h2:    next_cmd = {cmd_sh[5:0], io_s2[1:0]};
         default: next_cmd = {cmd_sh[6:0], io_s2[0]};
      endcase
      next_bit_cnt = bit_cnt + {3'h0, lanes};
   end

   // stretched ready time after an interrupted subsector erase
   always_comb
   begin
      unique case (cfg[sfxpc_pkg::CFG_REC_LSB +: 2])
         sfxpc_pkg::REC_4K:  wait_len = 24'(REC4K_CYCLES);
         sfxpc_pkg::REC_32K: wait_len = 24'(REC32K_CYCLES);
         default:            wait_len = 24'(READY_WAIT_CYCLES);
      endcase
   end

   // ==========================================================
   // readiness after power-up
   always_ff @(posedge clk_sys_in)
   begin
      if (logic_rst)
      begin
         init_cnt <= 24'h000000;
         ready    <= 1'b0;
      end
      else if (!ready)
      begin
         init_cnt <= init_cnt + 24'h000001;
         ready    <= (init_cnt + 24'h000001) >= wait_len;
      end
   end

   // pause function on and default drive during the ready wait
   assign pause_en_out      = 1'b1;
   assign drive_default_out = 1'b1;

   // ==========================================================
   // hardware reset pin, honoured only after ready and if fitted
   always_ff @(posedge clk_sys_in)
   begin
      if (logic_rst)
         rpin_low_q <= 1'b0;
      else
         rpin_low_q <= ~rpin_sync[1];
   end

   // falling pin edge; in four-line protocol only while deselected
   assign rpin_hit = ~rpin_sync[1] & ~rpin_low_q & ready
                     & cfg[sfxpc_pkg::CFG_RPIN_BIT]
                     & (cfg[sfxpc_pkg::CFG_QUAD_BIT] | ~sel_low);

   // ==========================================================
   // status bytes; busy and initialising both read as in progress
   assign status_byte = {6'h00, wel, op_busy | ~ready};
   assign flag_byte   = {~(op_busy | ~ready), 7'h00};

   // ==========================================================
   // serial engine
   always_ff @(posedge clk_sys_in)
   begin
      soft_rst <= 1'b0;
      if (logic_rst)
      begin
         spi_state <= SP_CMD;
         bit_cnt   <= 6'h00;
         cmd_sh    <= 8'h00;
         out_sh    <= 8'h00;
         out_bit   <= 1'b0;
         from_cmd  <= 1'b0;
         soft_rst  <= 1'b0;
      end
      else if (!sel_low)
      begin
         // each select-low starts at address when execute mode is on
         spi_state <= xip_active ? SP_ADDR : SP_CMD;
         bit_cnt   <= 6'h00;
         from_cmd  <= 1'b0;
         if (sel_rise && rst_armed && cmd_sh == sfxpc_pkg::CMD_RSTMEM)
            soft_rst <= 1'b1;
      end
      else
      begin
         unique case (spi_state)
            SP_CMD:
               if (sclk_rise)
               begin
                  cmd_sh  <= next_cmd;
                  bit_cnt <= next_bit_cnt;
                  if (next_bit_cnt >= 6'h08)
                  begin
                     bit_cnt <= 6'h00;
                     // only the two status reads pass during initialisation
                     if (next_cmd == sfxpc_pkg::CMD_RDSR)
                     begin
                        spi_state <= SP_OUT;
                        out_sh    <= status_byte;
                     end
                     else if (next_cmd == sfxpc_pkg::CMD_RDFSR)
                     begin
                        spi_state <= SP_OUT;
                        out_sh    <= flag_byte;
                     end
                     else if (ready && next_cmd == sfxpc_pkg::CMD_FREAD)
                     begin
                        spi_state <= SP_ADDR;
                        from_cmd  <= 1'b1;
                     end
                     else
                        spi_state <= SP_IGNORE;
                  end
               end
            SP_ADDR:
               if (sclk_rise)
               begin
                  bit_cnt <= next_bit_cnt;
                  if (next_bit_cnt >= sfxpc_pkg::ADDR_BITS)
                     spi_state <= SP_DUMMY;
               end
            SP_DUMMY:
               if (sclk_rise)
                  spi_state <= SP_IGNORE;
            SP_OUT:
               if (sclk_fall)
               begin
                  // status bytes repeat while select stays low
                  out_bit <= out_sh[7];
                  out_sh  <= {out_sh[6:0], out_sh[7]};
               end
            SP_IGNORE:
               spi_state <= SP_IGNORE;
         endcase
      end
   end

   // ==========================================================
   // execute mode state; only io_line0 is looked at in the dummy cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (logic_rst)
         xip_active <= xip_en;
      else if (rpin_hit || soft_rst)
         xip_active <= xip_en;
      else if (sel_low && spi_state == SP_DUMMY && sclk_rise)
      begin
         // io_line3..1 are never read here
         if (xip_active || (from_cmd && xip_en))
            xip_active <= ~io_s2[0];
      end
   end

   // ==========================================================
   // write latch and reset arming; cleared at power-up
   always_ff @(posedge clk_sys_in)
   begin
      if (logic_rst || soft_rst || rpin_hit)
      begin
         wel       <= 1'b0;
         rst_armed <= 1'b0;
      end
      else if (sel_rise && spi_state == SP_IGNORE && ready)
      begin
         if (cmd_sh == sfxpc_pkg::CMD_WREN)
            wel <= 1'b1;
         else if (cmd_sh == sfxpc_pkg::CMD_WRDI)
            wel <= 1'b0;
         rst_armed <= cmd_sh == sfxpc_pkg::CMD_RSTEN;
      end
   end

   // ==========================================================
   // pin drive: only io_line1 carries data, enable low while driving
   always_comb
   begin
      pins_out         = '0;
      pins_out.io_oe_n = 4'hf;
      pins_out.io[1]   = out_bit;
      if (sel_low && spi_state == SP_OUT)
         pins_out.io_oe_n[1] = 1'b0;
   end

   // ==========================================================
   // apb slave: zero wait, error on unmapped address
   assign apb_hit = apb_in.paddr[31:0] == {20'h00000, sfxpc_pkg::CFG_OFS}
                    || apb_in.paddr[31:0] == {20'h00000, sfxpc_pkg::OPER_OFS}
                    || apb_in.paddr[31:0] == {20'h00000, sfxpc_pkg::STATE_OFS};

   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         cfg     <= sfxpc_pkg::CFG_RST;
         op_busy <= 1'b0;
      end
      else
      begin
         // the escape bursts never touch the running operation
         if (logic_rst)
            op_busy <= 1'b0;
         if (apb_in.psel && apb_in.penable && apb_in.pwrite)
         begin
            // unmapped addresses alias on the low bits, so the full match gates it
            if (apb_hit && apb_in.paddr[11:0] == sfxpc_pkg::CFG_OFS)
               cfg <= apb_in.pwdata;
            if (apb_in.paddr[11:0] == sfxpc_pkg::OPER_OFS && apb_hit && !logic_rst)
               op_busy <= apb_in.pwdata[0];
         end
      end
   end

   // read data mux
   always_comb
   begin
      apb_out.pready  = 1'b1;
      apb_out.pslverr = apb_in.psel & apb_in.penable & ~apb_hit;
      apb_out.prdata  = 32'h0000_0000;
      if (apb_in.paddr == {20'h00000, sfxpc_pkg::CFG_OFS})
         apb_out.prdata = cfg;
      else if (apb_in.paddr == {20'h00000, sfxpc_pkg::OPER_OFS})
         apb_out.prdata = {31'h0, op_busy};
      else if (apb_in.paddr == {20'h00000, sfxpc_pkg::STATE_OFS})
      begin
         apb_out.prdata[sfxpc_pkg::ST_READY]  = ready;
         apb_out.prdata[sfxpc_pkg::ST_XIP]    = xip_active;
         apb_out.prdata[sfxpc_pkg::ST_WEL]    = wel;
         apb_out.prdata[sfxpc_pkg::ST_WIP]    = op_busy | ~ready;
         apb_out.prdata[sfxpc_pkg::ST_LOCK]   = 1'b0;
         apb_out.prdata[sfxpc_pkg::ST_LOCKDN] = 1'b0;
      end
   end
endmodule // sfxpc_ctrl
`default_nettype wire

// ### sfxpc_pkg.sv
// shared constants and pin bundles for the execute mode and power-up controller
`default_nettype none
package sfxpc_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [11:0] CFG_OFS       = 12'h000;
   localparam logic [11:0] OPER_OFS      = 12'h004;
   localparam logic [11:0] STATE_OFS     = 12'h008;
   localparam logic [31:0] CFG_RST       = 32'h0000_ffff;
   // persistent configuration fields
   localparam int          CFG_XIP_LSB   = 9;      // [11:9] execute mode select
   localparam logic [2:0]  CFG_XIP_OFF   = 3'h7;   // erased value, mode disabled
   localparam int          CFG_QUAD_BIT  = 7;      // 0 selects four-line protocol
   localparam int          CFG_DUAL_BIT  = 6;      // 0 selects two-line protocol
   localparam int          CFG_RPIN_BIT  = 16;     // 1 = reset pin fitted on this part
   localparam int          CFG_REC_LSB   = 17;     // [18:17] interrupted erase kind
   localparam logic [1:0]  REC_NONE      = 2'h0;
   localparam logic [1:0]  REC_4K        = 2'h1;
   localparam logic [1:0]  REC_32K       = 2'h2;
   // state register fields
   localparam int          ST_READY      = 0;
   localparam int          ST_XIP        = 1;
   localparam int          ST_WEL        = 2;
   localparam int          ST_WIP        = 3;
   localparam int          ST_LOCK       = 4;
   localparam int          ST_LOCKDN     = 5;
   // ==========================================================
   // command codes
   localparam logic [7:0]  CMD_RDSR      = 8'h05;
   localparam logic [7:0]  CMD_RDFSR     = 8'h70;
   localparam logic [7:0]  CMD_WREN      = 8'h06;
   localparam logic [7:0]  CMD_WRDI      = 8'h04;
   localparam logic [7:0]  CMD_RSTEN     = 8'h66;
   localparam logic [7:0]  CMD_RSTMEM    = 8'h99;
   localparam logic [7:0]  CMD_FREAD     = 8'h0b;
   localparam logic [5:0]  ADDR_BITS     = 6'h18;
   // ==========================================================
   // timing
   localparam int          CLK_NS        = 40;
   localparam int          READY_WAIT_NS = 300000;
   localparam int          REC4K_NS      = 4500000;
   localparam int          REC32K_NS     = 36000000;
   localparam int          READY_WAIT_CYC = READY_WAIT_NS / CLK_NS;
   localparam int          REC4K_CYC      = REC4K_NS / CLK_NS;
   localparam int          REC32K_CYC     = REC32K_NS / CLK_NS;
   // ==========================================================
   // pin and apb bundles
   typedef struct packed {
      logic       select_n;
      logic       sclk;
      logic       reset_n;
      logic [3:0] io;
   } sfxpc_pins_in_t;
   typedef struct packed {
      logic [3:0] io;
      logic [3:0] io_oe_n;
   } sfxpc_pins_out_t;
   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } sfxpc_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sfxpc_apb_rsp_t;
endpackage
`default_nettype wire

// ### sfxpc_ctrl_monitor.sv
// concurrent checks on the ports of the execute mode and power-up controller
`timescale 1ns/10ps
`default_nettype none
module sfxpc_ctrl_monitor #(
   parameter int READY_WAIT_CYCLES = 7500,
   parameter int REC4K_CYCLES      = 112500,
   parameter int REC32K_CYCLES     = 900000
) (
   // clock and reset
   input wire logic                       clk_sys_in,
   input wire logic                       rst_n_in,
   input wire logic                       por_n_in,
   // flash pins
   input wire sfxpc_pkg::sfxpc_pins_in_t  pins_in,
   input wire sfxpc_pkg::sfxpc_pins_out_t pins_out,
   // fixed pin functions
   input wire logic                       pause_en_out,
   input wire logic                       drive_default_out,
   // apb
   input wire sfxpc_pkg::sfxpc_apb_req_t  apb_in,
   input wire sfxpc_pkg::sfxpc_apb_rsp_t  apb_out
);
   int   up_cnt;
   logic acc;
   logic rd_state;
   logic mapped;
   // ==========================================================
   // helpers
   // cycles since both resets let go, held at a ceiling
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_n_in || !por_n_in)
         up_cnt <= 0;
      else if (up_cnt < REC32K_CYCLES + 16)
         up_cnt <= up_cnt + 1;
   end
   // access phase decode
   assign acc      = apb_in.psel && apb_in.penable;
   assign rd_state = acc && !apb_in.pwrite && apb_in.paddr == {20'h0, sfxpc_pkg::STATE_OFS};
   assign mapped   = apb_in.paddr[11:0] <= 12'h008;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // assertions
   AST_FIXED_PINS: assert property (pause_en_out && drive_default_out)
      else $error("pause or drive default output low");
   AST_ONLY_IO1: assert property (pins_out.io_oe_n[3:2] == 2'b11 && pins_out.io_oe_n[0])
      else $error("data line other than io1 driven");
   AST_DESEL_QUIET: assert property (pins_in.select_n [*6] |-> pins_out.io_oe_n[1])
      else $error("io1 driven while deselected");
   AST_POR_QUIET: assert property (!por_n_in [*5] |-> pins_out.io_oe_n == 4'hf)
      else $error("output driven during power-on reset");
   AST_ZERO_WAIT: assert property (acc |-> apb_out.pready)
      else $error("pready low in access phase");
   AST_SLVERR: assert property (acc && apb_in.paddr[31:12] == 20'h0 && apb_in.paddr[1:0] == 2'h0
                                |-> apb_out.pslverr == !mapped)
      else $error("pslverr does not match address map");
   AST_LOCKS_CLEAR: assert property (rd_state |-> apb_out.prdata[5:4] == 2'b00)
      else $error("lock bits set");
   AST_READY_EARLY: assert property (rd_state && up_cnt < READY_WAIT_CYCLES
                                     |-> !apb_out.prdata[sfxpc_pkg::ST_READY])
      else $error("ready before wait elapsed");
   AST_READY_LATE: assert property (rd_state && up_cnt > REC32K_CYCLES + 8
                                    |-> apb_out.prdata[sfxpc_pkg::ST_READY])
      else $error("ready missing after longest wait");
   // main scenarios
   COV_READY: cover property (rd_state && apb_out.prdata[sfxpc_pkg::ST_READY]);
   COV_IO1: cover property (!pins_out.io_oe_n[1]);
   COV_ERR: cover property (acc && apb_out.pslverr);
endmodule // sfxpc_ctrl_monitor
bind sfxpc_ctrl sfxpc_ctrl_monitor #(
   .READY_WAIT_CYCLES(READY_WAIT_CYCLES),
   .REC4K_CYCLES(REC4K_CYCLES),
   .REC32K_CYCLES(REC32K_CYCLES)
) u_sfxpc_ctrl_monitor (
   .clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in),
   .por_n_in(por_n_in),
   .pins_in(pins_in),
   .pins_out(pins_out),
   .pause_en_out(pause_en_out),
   .drive_default_out(drive_default_out),
   .apb_in(apb_in),
   .apb_out(apb_out)
);
`default_nettype wire

// ### sfxpc_host_model.sv
// host flash controller model driving select, serial clock and data lines
`timescale 1ns/10ps
`default_nettype none
module sfxpc_host_model (
   // clock
   input  wire logic                       clk_sys_in,
   // device side
   input  wire sfxpc_pkg::sfxpc_pins_out_t dev_in,
   output var  sfxpc_pkg::sfxpc_pins_in_t  pins_out
);
   logic       sel_n;
   logic       sclk;
   logic       rst_pin_n;
   logic [3:0] io_drv;
   // io1 comes from the device while it drives, else from the host
   always_comb
   begin
      pins_out.select_n = sel_n;
      pins_out.sclk     = sclk;
      pins_out.reset_n  = rst_pin_n;
      pins_out.io       = {io_drv[3:2], dev_in.io_oe_n[1] ? io_drv[1] : dev_in.io[1], io_drv[0]};
   end
   initial
   begin
      sel_n     = 1'b1;
      sclk      = 1'b0;
      rst_pin_n = 1'b1;
      io_drv    = 4'hf;   // io3 held high in every frame
   end
   // one select-low frame of n clocks, msb first on io0, io1 captured
   task automatic frame(input logic [63:0] d, input int n, output logic [7:0] rx);
      logic [63:0] sh;
      sh = '0;
      sel_n <= 1'b0;
      for (int k = 0; k < n; k++)
      begin
         sh = {sh[62:0], pins_out.io[1]};
         sclk      <= 1'b0;
         io_drv[0] <= d[n-1-k];
         repeat (4) @(posedge clk_sys_in);
         sclk <= 1'b1;
         repeat (4) @(posedge clk_sys_in);
      end
      sh = {sh[62:0], pins_out.io[1]};
      rx = sh[7:0];
      sel_n <= 1'b1;
      @(posedge clk_sys_in);
      sclk      <= 1'b0;
      io_drv[0] <= ~io_drv[0];   // released line does not keep its level
      repeat (8) @(posedge clk_sys_in);
   endtask
   // low pulse on the reset pin, only while deselected
   task automatic pin_reset();
      rst_pin_n <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
      rst_pin_n <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
   endtask
endmodule // sfxpc_host_model
`default_nettype wire

// ### sfxpc_ctrl_tb_top.sv
// self-checking testbench of the execute mode and power-up controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module sfxpc_ctrl_tb_top;
   localparam int WAIT_CYC = 400;
   logic                       clk_sys_in;
   logic                       rst_n_in;
   logic                       por_n_in;
   sfxpc_pkg::sfxpc_pins_in_t  pins_in;
   sfxpc_pkg::sfxpc_pins_out_t pins_out;
   sfxpc_pkg::sfxpc_apb_req_t  apb_req;
   sfxpc_pkg::sfxpc_apb_rsp_t  apb_rsp;
   int                         err_count;
   int                         checked;
   logic [31:0]                rd;
   logic                       er;
   logic [7:0]                 sb;
   int                         t;
   int                         burst_len [6] = '{7, 9, 13, 17, 25, 33};
   sfxpc_ctrl #(.READY_WAIT_CYCLES(WAIT_CYC), .REC4K_CYCLES(480), .REC32K_CYCLES(560)) u_sfxpc_ctrl (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
      .pins_in(pins_in), .pins_out(pins_out), .pause_en_out(), .drive_default_out(),
      .apb_in(apb_req), .apb_out(apb_rsp));
   sfxpc_host_model u_sfxpc_host_model (
      .clk_sys_in(clk_sys_in), .dev_in(pins_out), .pins_out(pins_in));
   // ==========================================================
   // bus tasks
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      apb_req.paddr   <= {20'h0, a};
      apb_req.pwrite  <= w;
      apb_req.pwdata  <= wd;
      apb_req.psel    <= 1'b1;
      @(posedge clk_sys_in);
      apb_req.penable <= 1'b1;
      // wait as long as the slave stretches the access phase
      do
         @(posedge clk_sys_in);
      while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic sreg(input logic [7:0] c);
      u_sfxpc_host_model.frame({48'h0, c, 8'h00}, 16, sb);
   endtask
   task automatic cmd(input logic [7:0] c);
      u_sfxpc_host_model.frame({56'h0, c}, 8, sb);
   endtask
   task automatic por_cycle(input int w);
      por_n_in <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      por_n_in <= 1'b1;
      repeat (w) @(posedge clk_sys_in);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // clock and watchdog
   initial
   begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      #2000000;
      err_count++;
      end_of_test();
   end
   // ==========================================================
   // test sequence
   initial
   begin
      err_count = 0;
      checked   = 0;
      rst_n_in  = 1'b0;
      por_n_in  = 1'b0;
      apb_req   = '0;
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      por_n_in <= 1'b1;
      @(posedge clk_sys_in);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("ready early", 1'b0, rd[0])
      apb(sfxpc_pkg::CFG_OFS, 1'b0, 32'h0);
      `CHK("cfg reset", sfxpc_pkg::CFG_RST, rd)
      sreg(sfxpc_pkg::CMD_RDSR);
      `CHK("status init", 1'b1, sb[0])
      sreg(sfxpc_pkg::CMD_RDFSR);
      `CHK("flag init", 1'b0, sb[7])
      cmd(sfxpc_pkg::CMD_WREN);
      t = 0;
      do
      begin
         sreg(sfxpc_pkg::CMD_RDFSR);
         t++;
      end
      while (sb[7] !== 1'b1 && t < 20);
      `CHK("poll ready", 1'b1, sb[7])
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("state ready", 6'h01, rd[5:0])
      sreg(sfxpc_pkg::CMD_RDSR);
      `CHK("status ready", 2'b00, sb[1:0])
      apb(12'h00c, 1'b0, 32'h0);
      `CHK("unmapped", 1'b1, er)
      apb(sfxpc_pkg::OPER_OFS, 1'b1, 32'h1);
      repeat (2)
      begin
         sreg(sfxpc_pkg::CMD_RDFSR);
         `CHK("flag busy", 1'b0, sb[7])
      end
      apb(sfxpc_pkg::OPER_OFS, 1'b1, 32'h0);
      sreg(sfxpc_pkg::CMD_RDFSR);
      `CHK("flag done", 1'b1, sb[7])
      // boot straight into execute mode, reset pin fitted
      apb(sfxpc_pkg::CFG_OFS, 1'b1, 32'h0001_f1ff);
      por_cycle(WAIT_CYC + 10);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("boot exec", 2'b11, rd[1:0])
      apb(sfxpc_pkg::OPER_OFS, 1'b1, 32'h1);
      u_sfxpc_host_model.frame(64'h200, 25, sb);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("exec kept", 1'b1, rd[1])
      for (int i = 0; i < 6; i++)
         u_sfxpc_host_model.frame('1, burst_len[i], sb);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("escape", 3'b100, rd[3:1])
      sreg(sfxpc_pkg::CMD_RDSR);
      `CHK("command again", 1'b1, sb[0])
      u_sfxpc_host_model.pin_reset();
      repeat (WAIT_CYC + 10) @(posedge clk_sys_in);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("pin reset", 1'b1, rd[1])
      u_sfxpc_host_model.frame(64'h201, 25, sb);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("exec left", 1'b0, rd[1])
      // fast read with confirmation 0 enters execute mode from command mode
      u_sfxpc_host_model.frame(64'h1600_0000, 33, sb);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("exec entry", 1'b1, rd[1])
      u_sfxpc_host_model.frame(64'h201, 25, sb);
      cmd(sfxpc_pkg::CMD_WREN);
      sreg(sfxpc_pkg::CMD_RDSR);
      `CHK("wel set", 1'b1, sb[1])
      cmd(sfxpc_pkg::CMD_RSTEN);
      cmd(sfxpc_pkg::CMD_RSTMEM);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("soft reset", 2'b01, rd[2:1])
      // four-line protocol: io_line3..1 high in the dummy cycle do not end the mode
      apb(sfxpc_pkg::CFG_OFS, 1'b1, 32'h0001_f17f);
      u_sfxpc_host_model.frame(64'h0, 7, sb);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("quad ignore", 1'b1, rd[1])
      apb(sfxpc_pkg::OPER_OFS, 1'b1, 32'h0);
      // interrupted 4KB erase stretches the ready time
      apb(sfxpc_pkg::CFG_OFS, 1'b1, 32'h0003_ffff);
      por_cycle(WAIT_CYC + 10);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("recovery busy", 1'b0, rd[0])
      repeat (100) @(posedge clk_sys_in);
      apb(sfxpc_pkg::STATE_OFS, 1'b0, 32'h0);
      `CHK("recovery done", 1'b1, rd[0])
      end_of_test();
   end
endmodule // sfxpc_ctrl_tb_top
`default_nettype wire
